// ---- rtl/flash_regs_map.svh ----
`ifndef FLASH_REGS_MAP_SVH
`define FLASH_REGS_MAP_SVH

// Serial opcodes
`define OP_READ_ANY 8'h65
`define OP_WRITE_ANY 8'h71

// Register addresses carried in the byte after the opcode
`define ADDR_SUSPEND_ERASE_STATUS 8'h03
`define ADDR_PERSISTENT_CONFIG 8'h02

// Status register fields
`define SR2_ERASE_RESULT 2
`define SR2_ERASE_SUSP 1
`define SR2_PROG_SUSP 0
`define SR2_RESET 8'h00

// Persistent configuration fields
`define CFG_ORIGIN 5
`define CFG_VOLATILITY 3
`define CFG_PARAM_LOC 2
`define CFG_WIDE_IO 1
`define CFG_FREEZE 0
`define CFG_RESET 8'h00
`define CFG_RW_MASK 8'h02
`define CFG_OTP_MASK 8'h2c
`define CFG_READ_MASK 8'h2f

// Protection extent in sixty-fourths of the array
`define PROT_WHOLE 7'h40
`define PROT_BP_ALL 3'h7
`define PROT_BP_NONE 3'h0

`define BITS_PER_BYTE_LAST 3'h7
`define BYTE_ZERO 8'h00

`endif

// ---- rtl/flash_regs_pkg.sv ----
package flash_regs_pkg;
    typedef enum logic [1:0] {
        F_CMD,
        F_ADDR,
        F_DATA,
        F_SKIP
    } frame_state_t;

    typedef logic [2:0] bp_t;
    typedef logic [6:0] extent_t;
endpackage

// ---- rtl/serial_link_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface serial_link_if;
    logic byte_valid;
    logic [7:0] rx_byte;
    logic cs_active;
    logic load;
    logic [7:0] tx_byte;
    logic drive;
    logic so;
    logic so_oe;

    modport front (
        output byte_valid,
        output rx_byte,
        output cs_active,
        output so,
        output so_oe,
        input load,
        input tx_byte,
        input drive
    );
    modport bank (
        input byte_valid,
        input rx_byte,
        input cs_active,
        input so,
        input so_oe,
        output load,
        output tx_byte,
        output drive
    );
endinterface
`default_nettype wire

// ---- rtl/serial_front.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "flash_regs_map.svh"
module serial_front (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    // Toward the register bank
    serial_link_if.front link
);
    typedef struct packed {
        logic sck_m;
        logic sck_s;
        logic sck_d;
        logic cs_m;
        logic cs_s;
        logic si_m;
        logic si_s;
        logic [7:0] rx_sr;
        logic [2:0] bit_cnt;
        logic byte_valid;
        logic [7:0] rx_byte;
        logic [7:0] tx_sr;
        logic so;
        logic so_oe;
    } front_t;

    front_t st_ff;
    front_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sck_m = sck;
        nxt_st.sck_s = st_ff.sck_m;
        nxt_st.sck_d = st_ff.sck_s;
        nxt_st.cs_m = cs_n;
        nxt_st.cs_s = st_ff.cs_m;
        nxt_st.si_m = si;
        nxt_st.si_s = st_ff.si_m;
        nxt_st.byte_valid = 1'b0;
        if (st_ff.cs_s) begin
            nxt_st.bit_cnt = '0;
            nxt_st.so_oe = 1'b0;
        end else begin
            // Mode 0: sample on rising, shift out on falling
            if (st_ff.sck_s && !st_ff.sck_d) begin
                nxt_st.rx_sr = {st_ff.rx_sr[6:0], st_ff.si_s};
                nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                if (st_ff.bit_cnt == `BITS_PER_BYTE_LAST) begin
                    nxt_st.byte_valid = 1'b1;
                    nxt_st.rx_byte = {st_ff.rx_sr[6:0], st_ff.si_s};
                end
            end
            if (!st_ff.sck_s && st_ff.sck_d) begin
                nxt_st.so = st_ff.tx_sr[7];
                nxt_st.tx_sr = {st_ff.tx_sr[6:0], 1'b0};
                nxt_st.so_oe = link.drive;
            end
        end
        if (link.load) begin
            nxt_st.tx_sr = link.tx_byte;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{cs_m: 1'b1, cs_s: 1'b1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.byte_valid = st_ff.byte_valid;
    assign link.rx_byte = st_ff.rx_byte;
    assign link.cs_active = !st_ff.cs_s;
    assign link.so = st_ff.so;
    assign link.so_oe = st_ff.so_oe;
endmodule
`default_nettype wire

// ---- rtl/flash_status2_config1_regs.sv ----
// What this block does
// - Status register two read-only, read-any only
// - Bit 2 holds latest erase-check result
// - Erase result invalid while suspended
// - Bit 1 shows erase suspended
// - Bit 0 shows program suspended
// - Config read 65h, written 71h
// - Config bits 7,6,4 reserved, zero
// - Bit 5 picks protection start end
// - Set one-time bit ignores zero write
// - Origin picks readable boot range
// - Protection 1/64 up to whole array
// - Bit 2 places parameter sectors
// - Bit 1 is quad-width default
// - Bit 0 read-only freeze default
// - Bit 3 selects volatile protection bits
`timescale 1ns/10ps
`default_nettype none
`include "flash_regs_map.svh"
module flash_status2_config1_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // Device status from core logic
    input wire logic erase_check_done,
    input wire logic erase_check_result,
    input wire logic erase_suspended,
    input wire logic program_suspended,
    input wire logic write_enable_latch,
    input wire logic uniform_sectors,
    input wire logic read_password_mode,
    input wire flash_regs_pkg::bp_t block_protection_bits,
    // Configuration toward core logic
    output logic protection_origin_bit,
    output logic protection_volatility_select,
    output logic parameter_sector_location,
    output logic wide_io_default,
    output logic freeze_default,
    output logic boot_low_readable,
    output logic boot_high_readable,
    output flash_regs_pkg::extent_t prot_lo,
    output flash_regs_pkg::extent_t prot_hi
);
    import flash_regs_pkg::*;

    typedef struct packed {
        frame_state_t state;
        logic is_read;
        logic [7:0] addr;
        logic erase_result_bit;
        logic erase_suspended_flag;
        logic program_suspended_flag;
        logic [7:0] cfg;
        logic load;
        logic [7:0] tx_byte;
        logic drive;
        logic boot_low;
        logic boot_high;
        logic param_top;
        extent_t lo;
        extent_t hi;
    } bank_t;

    bank_t st_ff;
    bank_t nxt_st;
    serial_link_if link ();

    serial_front u_front (
        .clock(clock),
        .rst_n(rst_n),
        .cs_n(cs_n),
        .sck(sck),
        .si(si),
        .link(link.front)
    );

    function automatic logic [7:0] read_value(input bank_t s, input logic [7:0] a);
        logic [7:0] v;
        v = `BYTE_ZERO;
        if (a == `ADDR_SUSPEND_ERASE_STATUS) begin
            // Erase result masked while suspended
            v[`SR2_ERASE_RESULT] = s.erase_result_bit
                && !(s.erase_suspended_flag || s.program_suspended_flag);
            v[`SR2_ERASE_SUSP] = s.erase_suspended_flag;
            v[`SR2_PROG_SUSP] = s.program_suspended_flag;
        end else if (a == `ADDR_PERSISTENT_CONFIG) begin
            v = s.cfg & `CFG_READ_MASK;
        end
        return v;
    endfunction

    function automatic extent_t extent(input bp_t bp);
        extent_t e;
        e = '0;
        if (bp == `PROT_BP_ALL) begin
            e = `PROT_WHOLE;
        end else if (bp != `PROT_BP_NONE) begin
            e = extent_t'(7'h01 << (bp - 3'h1));
        end
        return e;
    endfunction

    always_comb begin
        extent_t sz;
        sz = extent(block_protection_bits);
        nxt_st = st_ff;
        nxt_st.load = 1'b0;
        nxt_st.erase_suspended_flag = erase_suspended;
        nxt_st.program_suspended_flag = program_suspended;
        if (erase_check_done) begin
            nxt_st.erase_result_bit = erase_check_result;
        end
        if (!link.cs_active) begin
            nxt_st.state = F_CMD;
            nxt_st.drive = 1'b0;
        end else if (link.byte_valid) begin
            unique case (st_ff.state)
                F_CMD: begin
                    // Only the two register commands reach these registers
                    if (link.rx_byte == `OP_READ_ANY) begin
                        nxt_st.state = F_ADDR;
                        nxt_st.is_read = 1'b1;
                    end else if (link.rx_byte == `OP_WRITE_ANY) begin
                        nxt_st.state = F_ADDR;
                        nxt_st.is_read = 1'b0;
                    end else begin
                        nxt_st.state = F_SKIP;
                    end
                end
                F_ADDR: begin
                    nxt_st.addr = link.rx_byte;
                    nxt_st.state = F_DATA;
                    if (st_ff.is_read) begin
                        nxt_st.load = 1'b1;
                        nxt_st.tx_byte = read_value(st_ff, link.rx_byte);
                        nxt_st.drive = 1'b1;
                    end
                end
                F_DATA: begin
                    if (st_ff.is_read) begin
                        // Repeats the same register while clocked
                        nxt_st.load = 1'b1;
                        nxt_st.tx_byte = read_value(st_ff, st_ff.addr);
                    end else begin
                        nxt_st.state = F_SKIP;
                        if (write_enable_latch && st_ff.addr == `ADDR_PERSISTENT_CONFIG) begin
                            // One-time bits only set; reserved and read-only kept
                            nxt_st.cfg = (st_ff.cfg & ~`CFG_RW_MASK)
                                | (link.rx_byte & `CFG_RW_MASK)
                                | (link.rx_byte & `CFG_OTP_MASK);
                        end
                    end
                end
                F_SKIP: begin
                    nxt_st.state = F_SKIP;
                end
            endcase
        end
        nxt_st.boot_low = read_password_mode && !st_ff.cfg[`CFG_ORIGIN];
        nxt_st.boot_high = read_password_mode && st_ff.cfg[`CFG_ORIGIN];
        nxt_st.param_top = st_ff.cfg[`CFG_PARAM_LOC] && !uniform_sectors;
        if (st_ff.cfg[`CFG_ORIGIN]) begin
            nxt_st.lo = '0;
            nxt_st.hi = sz;
        end else begin
            nxt_st.lo = `PROT_WHOLE - sz;
            nxt_st.hi = `PROT_WHOLE;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{state: F_CMD, cfg: `CFG_RESET, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.load = st_ff.load;
    assign link.tx_byte = st_ff.tx_byte;
    assign link.drive = st_ff.drive;
    assign so = link.so;
    assign so_oe = link.so_oe;
    assign protection_origin_bit = st_ff.cfg[`CFG_ORIGIN];
    assign protection_volatility_select = st_ff.cfg[`CFG_VOLATILITY];
    assign parameter_sector_location = st_ff.param_top;
    assign wide_io_default = st_ff.cfg[`CFG_WIDE_IO];
    assign freeze_default = st_ff.cfg[`CFG_FREEZE];
    assign boot_low_readable = st_ff.boot_low;
    assign boot_high_readable = st_ff.boot_high;
    assign prot_lo = st_ff.lo;
    assign prot_hi = st_ff.hi;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_erase_result_bit_follows;
        erase_check_done |=> st_ff.erase_result_bit == $past(erase_check_result);
    endproperty
    a_erase_result_bit_follows: assert property (p_erase_result_bit_follows) else $error("erase result wrong");

    property p_erase_result_bit_holds;
        !erase_check_done |=> $stable(st_ff.erase_result_bit);
    endproperty
    a_erase_result_bit_holds: assert property (p_erase_result_bit_holds) else $error("erase result moved");

    logic erase_suspended_flag_q;
    assign erase_suspended_flag_q = st_ff.erase_suspended_flag;

    property p_erase_susp;
        erase_suspended[*2] |-> erase_suspended_flag_q;
    endproperty
    a_erase_susp: assert property (p_erase_susp) else $error("erase suspend flag");

    property p_prog_susp;
        !program_suspended ##1 1'b1 |-> !st_ff.program_suspended_flag;
    endproperty
    a_prog_susp: assert property (p_prog_susp) else $error("program suspend flag");

    property p_otp_sticky;
        (st_ff.cfg & `CFG_OTP_MASK) != 8'h00 |=> ((st_ff.cfg & `CFG_OTP_MASK)
            & $past(st_ff.cfg & `CFG_OTP_MASK)) == $past(st_ff.cfg & `CFG_OTP_MASK);
    endproperty
    a_otp_sticky: assert property (p_otp_sticky) else $error("one-time bit cleared");

    property p_reserved_zero;
        (st_ff.cfg & ~`CFG_READ_MASK) == 8'h00 && !st_ff.cfg[`CFG_FREEZE];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_prot_whole;
        block_protection_bits == `PROT_BP_ALL |=> prot_lo == 7'h00 && prot_hi == `PROT_WHOLE;
    endproperty
    a_prot_whole: assert property (p_prot_whole) else $error("whole array extent");

    property p_boot_high;
        read_password_mode && st_ff.cfg[`CFG_ORIGIN] |=> boot_high_readable && !boot_low_readable;
    endproperty
    a_boot_high: assert property (p_boot_high) else $error("boot range select");

    property p_param_uniform;
        uniform_sectors |=> !parameter_sector_location;
    endproperty
    a_param_uniform: assert property (p_param_uniform) else $error("parameter location");
endmodule
`default_nettype wire

// ---- verif/flash_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
    // Clock
    input wire logic clock,
    // Serial pins
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    localparam int HALF = 8;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // Deselected data line wanders
    always @(negedge clock) begin
        if (cs_n) begin
            si <= ~si;
        end
    end

    // Opcode, address, one data byte; read data captured on sck rise
    task automatic xfer(input logic [7:0] op, input logic [7:0] addr,
                        input logic [7:0] dat, output logic [7:0] rd);
        logic [23:0] sh;
        sh = {op, addr, dat};
        rd = 8'h00;
        @(negedge clock);
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(negedge clock);
            si = sh[i];
            repeat (HALF) @(negedge clock);
            if (i < 8) begin
                rd = {rd[6:0], so & so_oe};
            end
            sck = 1'b1;
            repeat (HALF) @(negedge clock);
            sck = 1'b0;
        end
        repeat (HALF) @(negedge clock);
        cs_n = 1'b1;
        repeat (6) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    import flash_regs_pkg::*;
    logic clock, rst_n, cs_n, sck, si, so, so_oe;
    logic erase_check_done, erase_check_result, erase_suspended, program_suspended;
    logic write_enable_latch, uniform_sectors, read_password_mode;
    bp_t block_protection_bits;
    logic protection_origin_bit, protection_volatility_select, parameter_sector_location;
    logic wide_io_default, freeze_default, boot_low_readable, boot_high_readable;
    extent_t prot_lo, prot_hi;
    logic [7:0] rd, cfg, d;
    int mismatches, num_checks;

    flash_status2_config1_regs flash_status2_config1_regs_i (.clock, .rst_n, .cs_n, .sck,
        .si, .so, .so_oe, .erase_check_done, .erase_check_result, .erase_suspended,
        .program_suspended, .write_enable_latch, .uniform_sectors, .read_password_mode,
        .block_protection_bits, .protection_origin_bit, .protection_volatility_select,
        .parameter_sector_location, .wide_io_default, .freeze_default, .boot_low_readable,
        .boot_high_readable, .prot_lo, .prot_hi);
    flash_host_model flash_host_model_i (.clock, .cs_n, .sck, .si, .so, .so_oe);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [7:0] exp_cfg(input logic [7:0] old, input logic [7:0] dat);
        return (old & 8'h2c) | (dat & 8'h2e);
    endfunction

    function automatic logic [6:0] ext_of(input bp_t b);
        return (b == 3'h0) ? 7'h00 : (b == 3'h7) ? 7'h40 : 7'h01 << (b - 3'h1);
    endfunction

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        flash_host_model_i.xfer(8'h65, a, 8'h00, v);
    endtask

    // All protection codes with random sector layout and password mode
    task automatic sweep;
        logic [6:0] e;
        for (int b = 0; b < 8; b++) begin
            block_protection_bits = 3'(b);
            uniform_sectors = 1'($urandom);
            read_password_mode = 1'($urandom);
            repeat (3) @(negedge clock);
            e = ext_of(block_protection_bits);
            chk({7'h0, protection_origin_bit}, {7'h0, cfg[5]});
            chk({7'h0, protection_volatility_select}, {7'h0, cfg[3]});
            chk({7'h0, parameter_sector_location}, {7'h0, cfg[2] & ~uniform_sectors});
            chk({7'h0, wide_io_default}, {7'h0, cfg[1]});
            chk({7'h0, freeze_default}, 8'h00);
            chk({6'h0, boot_high_readable, boot_low_readable},
                {6'h0, read_password_mode & cfg[5], read_password_mode & ~cfg[5]});
            chk({1'b0, prot_hi - prot_lo}, {1'b0, e});
            if (e != 7'h00)
                chk({1'b0, prot_lo}, cfg[5] ? 8'h00 : {1'b0, 7'h40 - e});
        end
    endtask

    initial begin
        // About twice the expected run length
        #400000;
        mismatches++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        {erase_check_done, erase_check_result, erase_suspended, program_suspended} = 4'h0;
        {write_enable_latch, uniform_sectors, read_password_mode} = 3'h0;
        block_protection_bits = 3'h0;
        cfg = 8'h00;
        mismatches = 0;
        num_checks = 0;
        void'($urandom(10870));
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        reg_rd(8'h03, rd);
        chk(rd, 8'h00);
        reg_rd(8'h02, rd);
        chk(rd, 8'h00);
        reg_rd(8'h05, rd);
        chk(rd, 8'h00);
        $display("test reset done");
        for (int n = 0; n < 16; n++) begin
            {erase_suspended, program_suspended, erase_check_result} = 3'($urandom);
            if (n < 3)
                {erase_suspended, program_suspended, erase_check_result} = 3'h1 << n;
            write_enable_latch = 1'b1;
            flash_host_model_i.xfer(8'h71, 8'h03, 8'hff, rd);
            erase_check_done = 1'b1;
            @(negedge clock);
            erase_check_done = 1'b0;
            reg_rd(8'h03, rd);
            chk(rd, {5'h00, erase_check_result & ~erase_suspended & ~program_suspended,
                     erase_suspended, program_suspended});
        end
        // Cleared erase result must survive an all-ones write
        {erase_suspended, program_suspended, erase_check_result} = 3'h0;
        erase_check_done = 1'b1;
        @(negedge clock);
        erase_check_done = 1'b0;
        reg_rd(8'h03, rd);
        chk(rd, 8'h00);
        flash_host_model_i.xfer(8'h71, 8'h03, 8'hff, rd);
        reg_rd(8'h03, rd);
        chk(rd, 8'h00);
        $display("test status done");
        sweep();
        write_enable_latch = 1'b0;
        flash_host_model_i.xfer(8'h71, 8'h02, 8'hff, rd);
        reg_rd(8'h02, rd);
        chk(rd, cfg);
        write_enable_latch = 1'b1;
        flash_host_model_i.xfer(8'h3c, 8'h02, 8'hff, rd);
        reg_rd(8'h02, rd);
        chk(rd, cfg);
        for (int n = 0; n < 10; n++) begin
            d = 8'($urandom);
            if (n < 3)
                d = (n == 0) ? 8'h02 : (n == 1) ? 8'hff : 8'h00;
            flash_host_model_i.xfer(8'h71, 8'h02, d, rd);
            cfg = exp_cfg(cfg, d);
            reg_rd(8'h02, rd);
            chk(rd, cfg);
        end
        $display("test config done");
        sweep();
        $display("test outputs done");
        results();
    end
endmodule
`default_nettype wire
